/* hdl/intc_pkg.sv */
// Types shared by the interrupt controller modules.
`default_nettype none
package intc_pkg;
  // One bit per source: 0 nonmaskable, 1-5 external 0-4, 6 watchdog, 7-11 timers, 12 serial,
  // 13 converter.
  typedef logic [13:0] src_vec_t;
  // Index of a source inside src_vec_t.
  typedef logic [3:0] src_idx_t;
  // Vector number handed to the CPU.
  typedef logic [5:0] vector_t;
  // Decoded register selection.
  typedef enum logic [3:0] {
    REG_NONE = 4'b0000,
    REG_SYSTEM_CONTROL = 4'b0001,
    REG_SENSE_CONTROL = 4'b0010,
    REG_LINE_ENABLE = 4'b0011,
    REG_PENDING_STATUS = 4'b0100,
    REG_PRIORITY_A = 4'b0101,
    REG_PRIORITY_B = 4'b0110,
    REG_EVENT_STATUS = 4'b0111,
    REG_EVENT_MASK = 4'b1000
  } reg_id_t;
  // APB slave phase: waiting for an access, or answering it.
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } bus_state_t;
endpackage : intc_pkg
`default_nettype wire

/* hdl/intc_regs.svh */
// Register indices, field positions, reset values and vector numbers of the interrupt controller.
`ifndef INTC_REGS_SVH
`define INTC_REGS_SVH

// Register indices; the APB byte address is four times the index.
`define IDX_SYSTEM_CONTROL 16'hFFF2
`define IDX_SENSE_CONTROL 16'hFFF4
`define IDX_LINE_ENABLE 16'hFFF5
`define IDX_PENDING_STATUS 16'hFFF6
`define IDX_PRIORITY_A 16'hFFF8
`define IDX_PRIORITY_B 16'hFFF9
`define IDX_EVENT_STATUS 16'hFFFC
`define IDX_EVENT_MASK 16'hFFFD

// Reset values.
`define RST_SYSTEM_CONTROL 8'h0B
`define RST_BYTE 8'h00

// Field positions inside the system control register.
`define BIT_USER_BIT_ENABLE 3
`define BIT_NONMASKABLE_EDGE_SELECT 2

// Vector numbers presented to the CPU core.
`define VEC_NMI 6'h07
`define VEC_EXT0 6'h0C
`define VEC_WATCHDOG 6'h14
`define VEC_TIMER0 6'h18
`define VEC_TIMER_STEP 6'h04
`define VEC_SERIAL 6'h34
`define VEC_CONVERTER 6'h3C

`endif

/* hdl/interrupt_controller.sv */
// Two-level interrupt controller with APB registers and vectored CPU requests.
// Operation
// - Maskable sources get one of two levels.
// - Three masking levels from mask and user bits.
// - Every source presents its own vector.
// - Nonmaskable request highest, always accepted.
// - External lines select falling edge or level.
// - Registers decoded at their fixed byte addresses.
// - System control resets to 0x0B, not in soft standby.
// - User-bit-enable 0 makes user bit a mask.
// - Edge select picks nonmaskable falling or rising edge.
// - Priority bit 0 low level, 1 high.
// - Register A bits 7-5 set external 0-3 levels.
// - Priority registers read/write, reset to 0x00.
// - Flags clear only by writing zero.
// - Register A bits 4-0: external 4, watchdog, timers.
// - Register B sets timers 3-4, serial, converter.
// - Status bits 7-5 read zero, 4-0 pending.
//
// Our own choice: the APB slave port.
`default_nettype none
`include "intc_regs.svh"
module interrupt_controller (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_standby,
  input wire logic nmi,
  input wire logic [4:0] ext_request_n,
  input wire logic watchdog_req,
  input wire logic [4:0] timer_req,
  input wire logic serial_req,
  input wire logic converter_req,
  input wire logic cpu_mask_bit,
  input wire logic user_or_mask_bit,
  input wire logic cpu_accept,
  output logic cpu_request,
  output intc_pkg::vector_t cpu_vector,
  output logic cpu_level_high,
  output logic irq
);
  import intc_pkg::*;

  // Bus group.
  bus_state_t bus_r, bus_nxt; // Slave phase.
  logic [31:0] prdata_r, prdata_nxt; // Registered read data.
  logic pslverr_r, pslverr_nxt; // Registered error answer.

  // Control group.
  logic [7:0] system_control_r, system_control_nxt;
  logic [7:0] request_sense_control_r, request_sense_control_nxt; // 1 edge, 0 level.
  logic [7:0] request_line_enable_r, request_line_enable_nxt;
  logic [4:0] request_pending_status_r, request_pending_status_nxt;
  logic [7:0] priority_level_a_r, priority_level_a_nxt;
  logic [7:0] priority_level_b_r, priority_level_b_nxt;
  logic [5:0] event_status_r, event_status_nxt; // Sticky event bits, write one to clear.
  logic [5:0] event_mask_r, event_mask_nxt; // Gates events onto irq.
  logic [4:0] ext_prev_r, ext_prev_nxt; // Line levels one cycle ago.
  logic nmi_prev_r, nmi_prev_nxt; // Nonmaskable pin one cycle ago.
  logic nmi_pend_r, nmi_pend_nxt; // Nonmaskable request waiting for acceptance.
  logic irq_r, irq_nxt; // Interrupt output.

  // CPU group.
  logic cpu_request_r, cpu_request_nxt;
  vector_t cpu_vector_r, cpu_vector_nxt;
  logic cpu_level_high_r, cpu_level_high_nxt;

  // Shared combinational terms.
  reg_id_t reg_id; // Register addressed by paddr.
  logic wr_en; // Write takes effect this edge.
  logic [4:0] ext_set; // Hardware setting of pending flags.
  logic nmi_edge; // Selected nonmaskable edge seen.
  src_vec_t src_req; // All raw requests.
  src_vec_t src_high; // Level of each source.
  src_vec_t src_gated; // Requests allowed by the CPU mask.
  logic arb_valid;
  src_idx_t arb_idx;
  logic arb_high;

  // Decodes a byte address into a register selection.
  function automatic reg_id_t decode(input logic [31:0] a);
    reg_id_t r;
    r = REG_NONE;
    if (a[31:18] == 14'h0000 && a[1:0] == 2'h0) begin
      case (a[17:2])
        `IDX_SYSTEM_CONTROL: r = REG_SYSTEM_CONTROL;
        `IDX_SENSE_CONTROL: r = REG_SENSE_CONTROL;
        `IDX_LINE_ENABLE: r = REG_LINE_ENABLE;
        `IDX_PENDING_STATUS: r = REG_PENDING_STATUS;
        `IDX_PRIORITY_A: r = REG_PRIORITY_A;
        `IDX_PRIORITY_B: r = REG_PRIORITY_B;
        `IDX_EVENT_STATUS: r = REG_EVENT_STATUS;
        `IDX_EVENT_MASK: r = REG_EVENT_MASK;
        default: r = REG_NONE;
      endcase
    end
    return r;
  endfunction : decode

  // Maps the priority bits onto the source order; unused bits of B are ignored.
  function automatic src_vec_t level_of(input logic [7:0] a, input logic [7:0] b);
    return {b[1], b[3], b[6], b[7], a[0], a[1], a[2], a[3], a[4], a[5], a[5], a[6], a[7],
            1'b1};
  endfunction : level_of

  // Gives each source its own vector number.
  function automatic vector_t vector_of(input src_idx_t i);
    vector_t v;
    case (i)
      4'h0: v = `VEC_NMI;
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5: v = `VEC_EXT0 + vector_t'(i - 4'h1);
      4'h6: v = `VEC_WATCHDOG;
      4'h7, 4'h8, 4'h9, 4'hA, 4'hB: v = `VEC_TIMER0 + vector_t'(6'(i - 4'h7) * `VEC_TIMER_STEP);
      4'hC: v = `VEC_SERIAL;
      4'hD: v = `VEC_CONVERTER;
      default: v = `VEC_NMI;
    endcase
    return v;
  endfunction : vector_of

  assign reg_id = decode(paddr);
  assign wr_en = psel && penable && pwrite && (bus_r == BUS_DONE);

  // Answers each access one cycle after it opens, with data and error registered.
  always_comb begin
    bus_nxt = BUS_IDLE;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (psel && penable && bus_r == BUS_IDLE) begin
      bus_nxt = BUS_DONE;
      pslverr_nxt = (reg_id == REG_NONE);
      case (reg_id)
        REG_SYSTEM_CONTROL: prdata_nxt = {24'h000000, system_control_r};
        REG_SENSE_CONTROL: prdata_nxt = {24'h000000, request_sense_control_r};
        REG_LINE_ENABLE: prdata_nxt = {24'h000000, request_line_enable_r};
        REG_PENDING_STATUS: prdata_nxt = {27'h0000000, request_pending_status_r};
        REG_PRIORITY_A: prdata_nxt = {24'h000000, priority_level_a_r};
        REG_PRIORITY_B: prdata_nxt = {24'h000000, priority_level_b_r};
        REG_EVENT_STATUS: prdata_nxt = {26'h0000000, event_status_r};
        REG_EVENT_MASK: prdata_nxt = {26'h0000000, event_mask_r};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Registers the bus group.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_r <= BUS_IDLE;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      bus_r <= bus_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Edge or level sensing of the external lines and of the nonmaskable pin.
  assign ext_set = (request_sense_control_r[4:0] & ext_prev_r & ~ext_request_n)
                 | (~request_sense_control_r[4:0] & ~ext_request_n);
  assign nmi_edge = system_control_r[`BIT_NONMASKABLE_EDGE_SELECT] ? (nmi && !nmi_prev_r)
                  : (!nmi && nmi_prev_r);

  // Computes the next control state; hardware standby restores reset values.
  always_comb begin
    system_control_nxt = system_control_r;
    request_sense_control_nxt = request_sense_control_r;
    request_line_enable_nxt = request_line_enable_r;
    priority_level_a_nxt = priority_level_a_r;
    priority_level_b_nxt = priority_level_b_r;
    request_pending_status_nxt = request_pending_status_r;
    event_status_nxt = event_status_r;
    event_mask_nxt = event_mask_r;
    if (wr_en) begin
      case (reg_id)
        REG_SYSTEM_CONTROL: system_control_nxt = pwdata[7:0];
        REG_SENSE_CONTROL: request_sense_control_nxt = pwdata[7:0];
        REG_LINE_ENABLE: request_line_enable_nxt = pwdata[7:0];
        REG_PENDING_STATUS: request_pending_status_nxt = request_pending_status_r
          & pwdata[4:0];
        REG_PRIORITY_A: priority_level_a_nxt = pwdata[7:0];
        REG_PRIORITY_B: priority_level_b_nxt = pwdata[7:0];
        REG_EVENT_STATUS: event_status_nxt = event_status_r & ~pwdata[5:0];
        REG_EVENT_MASK: event_mask_nxt = pwdata[5:0];
        default: event_mask_nxt = event_mask_r;
      endcase
    end
    // A setting condition wins over a clear in the same cycle.
    request_pending_status_nxt = request_pending_status_nxt | ext_set;
    event_status_nxt = event_status_nxt | {nmi_edge, ext_set & ~request_pending_status_r};
    ext_prev_nxt = ext_request_n;
    nmi_prev_nxt = nmi;
    nmi_pend_nxt = (nmi_pend_r && !(cpu_accept && cpu_vector_r == `VEC_NMI)) || nmi_edge;
    irq_nxt = |(event_status_r & event_mask_r);
    if (hw_standby) begin
      system_control_nxt = `RST_SYSTEM_CONTROL;
      request_sense_control_nxt = `RST_BYTE;
      request_line_enable_nxt = `RST_BYTE;
      priority_level_a_nxt = `RST_BYTE;
      priority_level_b_nxt = `RST_BYTE;
      request_pending_status_nxt = 5'h00;
      event_status_nxt = 6'h00;
      event_mask_nxt = 6'h00;
      nmi_pend_nxt = 1'b0;
    end
  end

  // Registers the control group.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_control_r <= `RST_SYSTEM_CONTROL;
      request_sense_control_r <= `RST_BYTE;
      request_line_enable_r <= `RST_BYTE;
      request_pending_status_r <= 5'h00;
      priority_level_a_r <= `RST_BYTE;
      priority_level_b_r <= `RST_BYTE;
      event_status_r <= 6'h00;
      event_mask_r <= 6'h00;
      ext_prev_r <= 5'h1F;
      nmi_prev_r <= 1'b0;
      nmi_pend_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      system_control_r <= system_control_nxt;
      request_sense_control_r <= request_sense_control_nxt;
      request_line_enable_r <= request_line_enable_nxt;
      request_pending_status_r <= request_pending_status_nxt;
      priority_level_a_r <= priority_level_a_nxt;
      priority_level_b_r <= priority_level_b_nxt;
      event_status_r <= event_status_nxt;
      event_mask_r <= event_mask_nxt;
      ext_prev_r <= ext_prev_nxt;
      nmi_prev_r <= nmi_prev_nxt;
      nmi_pend_r <= nmi_pend_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Gathers requests and applies the three-level CPU mask.
  assign src_req = {converter_req, serial_req, timer_req, watchdog_req,
                    request_pending_status_r & request_line_enable_r[4:0], nmi_pend_r};
  assign src_high = level_of(priority_level_a_r, priority_level_b_r);

  always_comb begin
    logic allow_high;
    logic allow_low;
    allow_low = !cpu_mask_bit;
    allow_high = !cpu_mask_bit
               || (!system_control_r[`BIT_USER_BIT_ENABLE] && !user_or_mask_bit);
    src_gated = src_req & ((src_high & {14{allow_high}}) | (~src_high & {14{allow_low}}));
    src_gated[0] = nmi_pend_r;
  end

  // Picks the winning source.
  vector_arbiter u_arbiter (
    .pclk(pclk),
    .presetn(presetn),
    .req(src_gated),
    .high(src_high),
    .grant_valid(arb_valid),
    .grant_idx(arb_idx),
    .grant_high(arb_high)
  );

  // Computes the request presented to the CPU.
  always_comb begin
    cpu_request_nxt = arb_valid;
    cpu_vector_nxt = vector_of(arb_idx);
    cpu_level_high_nxt = arb_valid && arb_high;
  end

  // Registers the CPU group.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_request_r <= 1'b0;
      cpu_vector_r <= `VEC_NMI;
      cpu_level_high_r <= 1'b0;
    end else begin
      cpu_request_r <= cpu_request_nxt;
      cpu_vector_r <= cpu_vector_nxt;
      cpu_level_high_r <= cpu_level_high_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = (bus_r == BUS_DONE);
  assign pslverr = pslverr_r;
  assign cpu_request = cpu_request_r;
  assign cpu_vector = cpu_vector_r;
  assign cpu_level_high = cpu_level_high_r;
  assign irq = irq_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Mask bit set with the user bit acting as a plain bit for three cycles.
  sequence s_all_masked;
    (cpu_mask_bit && system_control_r[`BIT_USER_BIT_ENABLE])[*3];
  endsequence

  // A falling nonmaskable edge, when falling is selected, is caught on the next edge.
  sequence s_nmi_fall;
    !system_control_r[`BIT_NONMASKABLE_EDGE_SELECT] && nmi_prev_r && !nmi && !hw_standby;
  endsequence

  AST_NMI_PRESENTED: assert property ($rose(nmi_pend_r) |-> ##2 (cpu_request &&
    cpu_vector == `VEC_NMI))
    else $error("Pending nonmaskable request not presented two cycles later.");
  AST_MASK_BLOCKS: assert property (s_all_masked |-> (!cpu_request ||
    cpu_vector == `VEC_NMI))
    else $error("Maskable request presented while fully masked.");
  AST_NMI_FALL: assert property (s_nmi_fall |=> nmi_pend_r)
    else $error("Falling nonmaskable edge not caught.");
  AST_EDGE_SENSE: assert property ((request_sense_control_r[0] && ext_prev_r[0] &&
    !ext_request_n[0] && !hw_standby) |=> request_pending_status_r[0])
    else $error("Falling edge on line 0 did not set its flag.");
  AST_LEVEL_SENSE: assert property ((!request_sense_control_r[1] && !ext_request_n[1] &&
    !hw_standby) |=> request_pending_status_r[1])
    else $error("Low level on line 1 did not set its flag.");
  AST_ONE_NEVER_SETS: assert property ((wr_en && reg_id == REG_PENDING_STATUS &&
    pwdata[2] && !request_pending_status_r[2] && !ext_set[2] && !hw_standby)
    |=> !request_pending_status_r[2])
    else $error("Writing one set a pending flag.");
  AST_ZERO_CLEARS: assert property ((wr_en && reg_id == REG_PENDING_STATUS &&
    !pwdata[3] && !ext_set[3] && !hw_standby) |=> !request_pending_status_r[3])
    else $error("Writing zero did not clear a pending flag.");
  AST_STANDBY_INIT: assert property (hw_standby |=> (system_control_r ==
    `RST_SYSTEM_CONTROL && priority_level_a_r == 8'h00 && priority_level_b_r == 8'h00))
    else $error("Hardware standby did not restore register values.");
  AST_UNMAPPED_ERR: assert property ((psel && penable && bus_r == BUS_IDLE &&
    reg_id == REG_NONE) |=> (pready && pslverr))
    else $error("Unmapped access not answered with an error.");
endmodule : interrupt_controller
`default_nettype wire

/* hdl/vector_arbiter.sv */
// Two-level fixed-order arbiter that picks one pending source per cycle.
`default_nettype none
module vector_arbiter (
  input wire logic pclk,
  input wire logic presetn,
  input wire intc_pkg::src_vec_t req,
  input wire intc_pkg::src_vec_t high,
  output logic grant_valid,
  output intc_pkg::src_idx_t grant_idx,
  output logic grant_high
);
  import intc_pkg::*;

  logic valid_r, valid_nxt; // A source won in the previous cycle.
  src_idx_t idx_r, idx_nxt; // Index of the winner.
  logic high_r, high_nxt; // Winner sat at level 1.

  // Lowest set index wins; the nonmaskable source sits at index 0.
  function automatic src_idx_t first_set(input src_vec_t v);
    src_idx_t k;
    k = 4'h0;
    for (int i = 13; i >= 0; i--) begin
      if (v[i]) begin
        k = src_idx_t'(i);
      end
    end
    return k;
  endfunction : first_set

  // Level 1 requests beat level 0 ones, ties go by index.
  always_comb begin
    src_vec_t hi_req;
    hi_req = req & high;
    valid_nxt = |req;
    high_nxt = |hi_req;
    if (req[0]) begin
      idx_nxt = 4'h0;
    end else if (|hi_req) begin
      idx_nxt = first_set(hi_req);
    end else begin
      idx_nxt = first_set(req);
    end
  end

  // Registers the decision.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_r <= 1'b0;
      idx_r <= 4'h0;
      high_r <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
      idx_r <= idx_nxt;
      high_r <= high_nxt;
    end
  end

  assign grant_valid = valid_r;
  assign grant_idx = idx_r;
  assign grant_high = high_r;

  // Whenever a level 1 source was asking, the winner must itself sit at level 1.
  AST_LOW_ONLY_WHEN_NO_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    (valid_r && $past(|(req & high))) |-> ((($past(high) >> idx_r) & 14'h0001) != 14'h0000))
    else $error("Level 0 source won over a pending level 1 source.");

  // The winner was itself requesting.
  AST_WINNER_REQUESTED: assert property (@(posedge pclk) disable iff (!presetn)
    valid_r |-> ((($past(req) >> idx_r) & 14'h0001) != 14'h0000))
    else $error("Granted source was not requesting.");
endmodule : vector_arbiter
`default_nettype wire

/* verif/cpu_core_model.sv */
// Behavioural model of the CPU core that takes vectored requests from the controller.
`default_nettype none
module cpu_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cpu_request,
  input wire intc_pkg::vector_t cpu_vector,
  input wire logic accept_en,
  output logic cpu_accept,
  output intc_pkg::vector_t taken_vector,
  output logic [7:0] taken_count
);
  timeunit 1ns;
  timeprecision 1ns;
  import intc_pkg::*;
  logic [1:0] gap_r; // Cycles left before another acceptance may start.

  // Accept a presented request with a one-cycle pulse, then back off while it drops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_accept <= 1'b0;
      taken_vector <= 6'h00;
      taken_count <= 8'h00;
      gap_r <= 2'h0;
    end else if (accept_en && cpu_request && !cpu_accept && gap_r == 2'h0) begin
      cpu_accept <= 1'b1;
      taken_vector <= cpu_vector; // The vector alone names the source.
      taken_count <= taken_count + 8'h01;
      gap_r <= 2'h3;
    end else begin
      cpu_accept <= 1'b0;
      gap_r <= (gap_r == 2'h0) ? 2'h0 : gap_r - 2'h1;
    end
  end
endmodule : cpu_core_model
`default_nettype wire

/* verif/two_level_interrupt_controller_tb.sv */
// Self-checking testbench of the two-level interrupt controller.
`default_nettype none
`include "intc_regs.svh"
module two_level_interrupt_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import intc_pkg::*;
  // One table row: internal requests, both priority bytes, expected vector and level.
  typedef struct packed {
    logic [7:0] src;
    logic [7:0] pa;
    logic [7:0] pb;
    vector_t vec;
    logic hi;
  } row_t;
  localparam row_t ROWS [10] = '{
    '{8'hFF, 8'h00, 8'h00, `VEC_WATCHDOG, 1'b0},
    '{8'hFF, 8'h04, 8'h00, `VEC_TIMER0, 1'b1},
    '{8'hFF, 8'h01, 8'h00, `VEC_TIMER0 + 6'h08, 1'b1},
    '{8'hFF, 8'h00, 8'h80, `VEC_TIMER0 + 6'h0C, 1'b1},
    '{8'hFF, 8'h00, 8'h40, `VEC_TIMER0 + 6'h10, 1'b1},
    '{8'hFF, 8'h00, 8'h08, `VEC_SERIAL, 1'b1},
    '{8'hFF, 8'h00, 8'h02, `VEC_CONVERTER, 1'b1},
    '{8'hFF, 8'h00, 8'h35, `VEC_WATCHDOG, 1'b0},
    '{8'hFF, 8'h08, 8'h00, `VEC_WATCHDOG, 1'b1},
    '{8'h80, 8'h00, 8'h00, `VEC_CONVERTER, 1'b0}
  };
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hw_standby, nmi;
  logic [31:0] paddr, pwdata, prdata;
  logic [4:0] ext_request_n, timer_req;
  logic watchdog_req, serial_req, converter_req, cpu_mask_bit, user_or_mask_bit;
  logic cpu_accept, cpu_request, cpu_level_high, irq, accept_en;
  vector_t cpu_vector, taken_vector;
  logic [7:0] taken_count;
  int err_total, checks_done, cycles;

  interrupt_controller u_interrupt_controller (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hw_standby(hw_standby),
    .nmi(nmi), .ext_request_n(ext_request_n), .watchdog_req(watchdog_req),
    .timer_req(timer_req), .serial_req(serial_req), .converter_req(converter_req),
    .cpu_mask_bit(cpu_mask_bit), .user_or_mask_bit(user_or_mask_bit),
    .cpu_accept(cpu_accept), .cpu_request(cpu_request), .cpu_vector(cpu_vector),
    .cpu_level_high(cpu_level_high), .irq(irq));
  cpu_core_model u_cpu_core_model (.pclk(pclk), .presetn(presetn),
    .cpu_request(cpu_request), .cpu_vector(cpu_vector), .accept_en(accept_en),
    .cpu_accept(cpu_accept), .taken_vector(taken_vector), .taken_count(taken_count));

  // Clock of 50 ns period and a cycle counter that cuts a hang short.
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      summarize();
    end
  end

  // Byte address of a register index.
  function automatic logic [31:0] adr(input logic [15:0] idx);
    return {14'h0000, idx, 2'b00};
  endfunction : adr

  // Compare one value and count it.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // One APB transfer: setup, access held until pready is sampled high.
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= adr(idx);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, idx, {24'h000000, d}, q, e);
  endtask : wr

  // Read a register and compare data and error response.
  task automatic rd(input string nm, input logic [15:0] idx, input logic [31:0] exp,
                    input logic experr);
    logic [31:0] q;
    logic e;
    apb(1'b0, idx, 32'h00000000, q, e);
    chk(nm, q, exp);
    chk("pslverr", {31'h0, e}, {31'h0, experr});
  endtask : rd

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, hw_standby, nmi, accept_en} = 6'h02;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    ext_request_n = 5'h1F;
    {watchdog_req, timer_req, serial_req, converter_req} = 8'h00;
    cpu_mask_bit = 1'b0;
    user_or_mask_bit = 1'b0;
    tick(6);
    presetn <= 1'b1;
    tick(1);
    // Reset values and the unmapped word.
    rd("sysctl", `IDX_SYSTEM_CONTROL, 32'h0000000B, 1'b0);
    rd("prio_a", `IDX_PRIORITY_A, 32'h00000000, 1'b0);
    rd("prio_b", `IDX_PRIORITY_B, 32'h00000000, 1'b0);
    rd("pending", `IDX_PENDING_STATUS, 32'h00000000, 1'b0);
    rd("unmapped", 16'hFFF3, 32'h00000000, 1'b1);
    $display("reset test done");
    // Table of priority settings against all internal requests, then the converter request alone.
    foreach (ROWS[i]) begin
      watchdog_req <= ROWS[i].src[0];
      timer_req <= ROWS[i].src[5:1];
      serial_req <= ROWS[i].src[6];
      converter_req <= ROWS[i].src[7];
      wr(`IDX_PRIORITY_A, ROWS[i].pa);
      wr(`IDX_PRIORITY_B, ROWS[i].pb);
      rd("prio_b", `IDX_PRIORITY_B, {24'h0, ROWS[i].pb}, 1'b0);
      chk("vector", {26'h0, cpu_vector}, {26'h0, ROWS[i].vec});
      chk("level", {31'h0, cpu_level_high}, {31'h0, ROWS[i].hi});
    end
    $display("priority table done");
    // Masking levels with timer channel 0 at level 1, then at level 0.
    {watchdog_req, timer_req, serial_req, converter_req} <= 8'h04;
    wr(`IDX_PRIORITY_A, 8'h04);
    wr(`IDX_PRIORITY_B, 8'h00);
    cpu_mask_bit <= 1'b1;
    tick(4);
    chk("masked all", {31'h0, cpu_request}, 32'h0);
    wr(`IDX_SYSTEM_CONTROL, 8'h03);
    tick(4);
    chk("ui mask lvl1", {31'h0, cpu_request}, 32'h1);
    user_or_mask_bit <= 1'b1;
    tick(4);
    chk("ui set", {31'h0, cpu_request}, 32'h0);
    user_or_mask_bit <= 1'b0;
    wr(`IDX_PRIORITY_A, 8'h00);
    tick(4);
    chk("ui mask lvl0", {31'h0, cpu_request}, 32'h0);
    {watchdog_req, timer_req, serial_req, converter_req} <= 8'h00;
    $display("masking test done");
    // Nonmaskable request on both edges while everything else is masked.
    nmi <= 1'b0;
    tick(4);
    chk("nmi fall", {25'h0, cpu_request, cpu_vector}, {26'h1, `VEC_NMI});
    accept_en <= 1'b1;
    tick(8);
    chk("nmi taken", {24'h0, taken_count}, 32'h1);
    chk("nmi drop", {31'h0, cpu_request}, 32'h0);
    wr(`IDX_SYSTEM_CONTROL, 8'h0F);
    nmi <= 1'b1;
    tick(8);
    chk("nmi rise", {18'h0, taken_count, taken_vector}, {18'h0, 8'h02, `VEC_NMI});
    accept_en <= 1'b0;
    cpu_mask_bit <= 1'b0;
    $display("nonmaskable test done");
    // Edge-sensed external request 0: flag, write-one ignored, vector, event interrupt.
    wr(`IDX_SENSE_CONTROL, 8'h01);
    wr(`IDX_LINE_ENABLE, 8'h01);
    ext_request_n[0] <= 1'b0;
    tick(4);
    ext_request_n[0] <= 1'b1;
    rd("pending", `IDX_PENDING_STATUS, 32'h00000001, 1'b0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(`IDX_PENDING_STATUS, 8'hFF);
    rd("pending w1", `IDX_PENDING_STATUS, 32'h00000001, 1'b0);
    chk("ext vector", {26'h0, cpu_vector}, {26'h0, `VEC_EXT0});
    // Top bit of priority A lifts external request 0 to level 1.
    wr(`IDX_PRIORITY_A, 8'h80);
    tick(2);
    chk("ext0 level", {31'h0, cpu_level_high}, 32'h1);
    wr(`IDX_EVENT_MASK, 8'h01);
    tick(2);
    chk("irq on", {31'h0, irq}, 32'h1);
    wr(`IDX_EVENT_STATUS, 8'h01);
    tick(2);
    chk("irq off", {31'h0, irq}, 32'h0);
    wr(`IDX_PENDING_STATUS, 8'hFE);
    rd("pending w0", `IDX_PENDING_STATUS, 32'h00000000, 1'b0);
    // Level-sensed request 1 sets again while the line stays low.
    ext_request_n[1] <= 1'b0;
    tick(2);
    wr(`IDX_PENDING_STATUS, 8'h00);
    rd("level", `IDX_PENDING_STATUS, 32'h00000002, 1'b0);
    ext_request_n[1] <= 1'b1;
    $display("external request test done");
    // Hardware standby restores the reset values.
    wr(`IDX_PRIORITY_A, 8'h55);
    hw_standby <= 1'b1;
    tick(1);
    hw_standby <= 1'b0;
    rd("sysctl hs", `IDX_SYSTEM_CONTROL, 32'h0000000B, 1'b0);
    rd("prio_a hs", `IDX_PRIORITY_A, 32'h00000000, 1'b0);
    $display("standby test done");
    summarize();
  end
endmodule : two_level_interrupt_controller_tb
`default_nettype wire
